// [hw/rseq_defs.svh]
// Overview of operation
// RQ1 - local command puts unit in local state and lifts panel lockout
// RQ2 - lockout command locks the panel, same as the bus lockout message
// RQ3 - remote command puts unit in remote state, same as bus remote enable
// RQ4 - fault pop read returns newest queued code, then removes it
// RQ5 - fault pop read of an empty queue answers zero
// RQ6 - error arriving on a full queue logs code 1, device class
// RQ7 - output on/off in measure or thermocouple source mode logs 100
// RQ8 - non-numeric entry in a numeric field logs 101
// RQ9 - numeric field longer than ten characters is rejected, logs 102
// RQ10 - unknown units name or prefix logs 103
// RQ11 - resistance source with probe selected, or reverse, logs 104
// RQ12 - entry above upper limit logs 105, below lower limit logs 106
// RQ13 - missing required parameter logs 108
// RQ14 - bad temperature unit token or bad pressure unit logs 109
// RQ15 - bad range hold parameter logs 110
// RQ16 - range hold on outside voltage mode is refused, logs 111
// RQ17 - bad sensor kind, junction reference, sensor select log 112-114
// RQ18 - no pressure module, pressure zero over 6%, tc zero over 1 mV log 116
// RQ19 - ohms zero over 0.1 ohm high or 0.01 ohm low range logs 116
// RQ20 - unrecognised command is discarded, logs 117
// RQ21 - classes map to status bits 5, 4, 3, 2 and completion bit 0
// RQ22 - each logged code also sets the status bit of its class
`ifndef RSEQ_DEFS_SVH
`define RSEQ_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define RSEQ_ADR_STATE 8'h00
`define RSEQ_ADR_CTX 8'h04
`define RSEQ_ADR_CMD 8'h08
`define RSEQ_ADR_ENTRY 8'h0c
`define RSEQ_ADR_LIM_HI 8'h10
`define RSEQ_ADR_LIM_LO 8'h14
`define RSEQ_ADR_ZERO 8'h18
`define RSEQ_ADR_FAULT 8'h1c
`define RSEQ_ADR_ESR 8'h20
// ****************************************
// reset values
// ****************************************
`define RSEQ_CTX_RST 8'h00
`define RSEQ_LIM_HI_RST 16'h7fff
`define RSEQ_LIM_LO_RST 16'h8000
// ****************************************
// command opcodes, bits 4:0 of command word
// ****************************************
`define RSEQ_OP_LOCAL 5'h01
`define RSEQ_OP_LOCKOUT 5'h02
`define RSEQ_OP_REMOTE 5'h03
`define RSEQ_OP_OUT_ON 5'h04
`define RSEQ_OP_OUT_OFF 5'h05
`define RSEQ_OP_HOLD_ON 5'h06
`define RSEQ_OP_HOLD_OFF 5'h07
`define RSEQ_OP_RTD_SRC 5'h08
`define RSEQ_OP_SPRT 5'h09
`define RSEQ_OP_NUM_LEN 5'h0a
`define RSEQ_OP_PRES_REQ 5'h0b
`define RSEQ_OP_NON_NUM 5'h0c
`define RSEQ_OP_BAD_UNITS 5'h0d
`define RSEQ_OP_MISSING 5'h0e
`define RSEQ_OP_BAD_TUNIT 5'h0f
`define RSEQ_OP_BAD_PUNIT 5'h10
`define RSEQ_OP_BAD_HOLD 5'h11
`define RSEQ_OP_BAD_KIND 5'h12
`define RSEQ_OP_BAD_JREF 5'h13
`define RSEQ_OP_BAD_TSEL 5'h14
`define RSEQ_OP_UNKNOWN 5'h15
`define RSEQ_OP_DONE 5'h16
// ****************************************
// context bit positions
// ****************************************
`define RSEQ_CTX_MEASURE 0
`define RSEQ_CTX_TC_SRC 1
`define RSEQ_CTX_RTD_SRC 2
`define RSEQ_CTX_SPRT 3
`define RSEQ_CTX_VOLT 4
`define RSEQ_CTX_PRES 5
`define RSEQ_CTX_OHM_HIGH 6
// ****************************************
// status bit positions
// ****************************************
`define RSEQ_ESR_CME 5
`define RSEQ_ESR_EXE 4
`define RSEQ_ESR_DDE 3
`define RSEQ_ESR_QYE 2
`define RSEQ_ESR_OPC 0
// ****************************************
// error codes
// ****************************************
`define RSEQ_E_NONE 7'd0
`define RSEQ_E_OVF 7'd1
`define RSEQ_E_OUT_MODE 7'd100
`define RSEQ_E_NON_NUM 7'd101
`define RSEQ_E_NUM_LEN 7'd102
`define RSEQ_E_UNITS 7'd103
`define RSEQ_E_SPRT 7'd104
`define RSEQ_E_ABOVE 7'd105
`define RSEQ_E_BELOW 7'd106
`define RSEQ_E_MISSING 7'd108
`define RSEQ_E_TUNIT 7'd109
`define RSEQ_E_HOLD_PAR 7'd110
`define RSEQ_E_HOLD_MODE 7'd111
`define RSEQ_E_KIND 7'd112
`define RSEQ_E_JREF 7'd113
`define RSEQ_E_TSEL 7'd114
`define RSEQ_E_ZERO 7'd116
`define RSEQ_E_UNKNOWN 7'd117
// ****************************************
// limits: numeric length, zero offsets
// ****************************************
`define RSEQ_NUM_MAX 8'd10
`define RSEQ_Z_PRES_MAX 16'd600
`define RSEQ_Z_TC_MAX 16'd1000
`define RSEQ_Z_OHM_HI_MAX 16'd100
`define RSEQ_Z_OHM_LO_MAX 16'd10
`define RSEQ_ZK_PRES 2'h0
`define RSEQ_ZK_TC 2'h1
`define RSEQ_ZK_OHM 2'h2
`define RSEQ_Q_DEPTH 8
`define RSEQ_Q_FULL 4'h8
`endif

// [hw/rseq_pkg.sv]
package rseq_pkg;
	// control state of the front panel
	typedef enum logic [1:0]
	{
		RSEQ_LOCAL = 2'b00,
		RSEQ_REMOTE = 2'b01,
		RSEQ_LOCKOUT = 2'b10
	} rseq_mode_t;

	// status class of a logged code
	typedef enum logic [1:0]
	{
		RSEQ_CME = 2'b00,
		RSEQ_EXE = 2'b01,
		RSEQ_DDE = 2'b10,
		RSEQ_QYE = 2'b11
	} rseq_class_t;

	// wishbone request bundle
	typedef struct packed
	{
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} rseq_wb_req_t;

	// whole module state
	typedef struct packed
	{
		rseq_mode_t mode;
		logic out_on;
		logic hold;
		logic [7:0] ctx;
		logic [15:0] lim_hi;
		logic [15:0] lim_lo;
		logic [7:0] esr;
		logic [7:0][6:0] stk;
		logic [3:0] cnt;
		logic ack;
		logic [31:0] rdat;
	} rseq_state_t;
endpackage

// [hw/rseq_top.sv]
`timescale 1ns/1ps
`include "rseq_defs.svh"
module rseq_top
	import rseq_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire rseq_wb_req_t i_wb,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output logic o_remote,
	output logic o_panel_locked,
	output logic o_output_active,
	output logic o_range_hold
);
	// ****************************************
	// helpers
	// ****************************************

	// class of each code, used by the push and the overflow path
	function automatic rseq_class_t code_class(input logic [6:0] c);
		case (c)
			`RSEQ_E_OVF: code_class = RSEQ_DDE;
			`RSEQ_E_OUT_MODE,
			`RSEQ_E_NUM_LEN,
			`RSEQ_E_SPRT,
			`RSEQ_E_ABOVE,
			`RSEQ_E_BELOW,
			`RSEQ_E_HOLD_MODE,
			`RSEQ_E_ZERO: code_class = RSEQ_EXE;
			default: code_class = RSEQ_CME;
		endcase
	endfunction

	// status bit for a class
	function automatic logic [7:0] class_bit(input rseq_class_t k);
		logic [7:0] b;
		b = 8'h00;
		case (k)
			RSEQ_CME: b[`RSEQ_ESR_CME] = 1'b1; // [RQ21]
			RSEQ_EXE: b[`RSEQ_ESR_EXE] = 1'b1; // [RQ21]
			RSEQ_DDE: b[`RSEQ_ESR_DDE] = 1'b1; // [RQ21]
			RSEQ_QYE: b[`RSEQ_ESR_QYE] = 1'b1; // [RQ21]
			default: b = 8'h00;
		endcase
		class_bit = b;
	endfunction

	// byte-lane merge for read/write registers
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// magnitude of a signed offset
	function automatic logic [15:0] mag(input logic [15:0] v);
		mag = v[15] ? 16'(-v) : v;
	endfunction

	rseq_state_t st;
	rseq_state_t next_st;
	logic [7:0][6:0] stk_push;
	logic [7:0][6:0] stk_pop;
	logic [6:0] new_code;

	// ****************************************
	// error stack shifts
	// ****************************************

	// newest entry lives in slot 0; push shifts up, pop shifts down
	assign stk_push[0] = new_code;
	assign stk_pop[`RSEQ_Q_DEPTH-1] = `RSEQ_E_NONE;
	genvar g;
	generate
		for (g = 1; g < `RSEQ_Q_DEPTH; g++)
		begin : g_shift
			assign stk_push[g] = st.stk[g-1];
			assign stk_pop[g-1] = st.stk[g];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************

	logic req;
	logic wr;
	logic rd;
	logic [4:0] op;
	logic [15:0] val;
	logic [15:0] zlim;
	logic [15:0] ctx32_lo;
	logic [31:0] tmp;

	// one access per bus cycle, so one error at most per clock
	always_comb
	begin
		next_st = st;
		next_st.ack = 1'b0;
		req = i_wb.cyc & i_wb.stb & ~st.ack;
		wr = req & i_wb.we;
		rd = req & ~i_wb.we;
		op = i_wb.dat[4:0];
		val = i_wb.dat[15:0];
		zlim = `RSEQ_Z_PRES_MAX;
		ctx32_lo = 16'h0000;
		tmp = 32'h0000_0000;
		new_code = `RSEQ_E_NONE;
		if (req)
		begin
			next_st.ack = 1'b1;
			next_st.rdat = 32'h0000_0000;
		end
		// register writes and command decode
		if (wr && i_wb.sel != 4'h0)
		begin
			case (i_wb.adr)
				`RSEQ_ADR_CTX:
				begin
					tmp = merge({24'h0, st.ctx}, i_wb.dat, i_wb.sel);
					next_st.ctx = tmp[7:0];
				end
				`RSEQ_ADR_LIM_HI:
				begin
					tmp = merge({16'h0, st.lim_hi}, i_wb.dat, i_wb.sel);
					next_st.lim_hi = tmp[15:0];
				end
				`RSEQ_ADR_LIM_LO:
				begin
					tmp = merge({16'h0, st.lim_lo}, i_wb.dat, i_wb.sel);
					next_st.lim_lo = tmp[15:0];
				end
				`RSEQ_ADR_ESR:
				begin
					// write one to clear; a same-cycle set is or-ed in below
					next_st.esr = st.esr & ~i_wb.dat[7:0];
				end
				`RSEQ_ADR_ENTRY:
				begin
					if ($signed(val) > $signed(st.lim_hi))
						new_code = `RSEQ_E_ABOVE; // [RQ12]
					else if ($signed(val) < $signed(st.lim_lo))
						new_code = `RSEQ_E_BELOW; // [RQ12]
				end
				`RSEQ_ADR_ZERO:
				begin
					case (i_wb.dat[17:16])
						`RSEQ_ZK_TC: zlim = `RSEQ_Z_TC_MAX; // [RQ18]
						`RSEQ_ZK_OHM: zlim = st.ctx[`RSEQ_CTX_OHM_HIGH] ?
							`RSEQ_Z_OHM_HI_MAX : `RSEQ_Z_OHM_LO_MAX; // [RQ19]
						default: zlim = `RSEQ_Z_PRES_MAX; // [RQ18]
					endcase
					if (i_wb.dat[17:16] == `RSEQ_ZK_PRES && !st.ctx[`RSEQ_CTX_PRES])
						new_code = `RSEQ_E_ZERO; // [RQ18]
					else if (mag(val) > zlim)
						new_code = `RSEQ_E_ZERO; // [RQ18] [RQ19]
				end
				`RSEQ_ADR_CMD:
				begin
					case (op)
						`RSEQ_OP_LOCAL: next_st.mode = RSEQ_LOCAL; // [RQ1]
						`RSEQ_OP_LOCKOUT: next_st.mode = RSEQ_LOCKOUT; // [RQ2]
						`RSEQ_OP_REMOTE:
						begin
							// remote enable never lifts an active lockout
							if (st.mode != RSEQ_LOCKOUT)
								next_st.mode = RSEQ_REMOTE; // [RQ3]
						end
						`RSEQ_OP_OUT_ON,
						`RSEQ_OP_OUT_OFF:
						begin
							if (st.ctx[`RSEQ_CTX_MEASURE] || st.ctx[`RSEQ_CTX_TC_SRC])
								new_code = `RSEQ_E_OUT_MODE; // [RQ7]
							else
								next_st.out_on = (op == `RSEQ_OP_OUT_ON);
						end
						`RSEQ_OP_HOLD_ON:
						begin
							if (!st.ctx[`RSEQ_CTX_VOLT])
								new_code = `RSEQ_E_HOLD_MODE; // [RQ16]
							else
								next_st.hold = 1'b1;
						end
						`RSEQ_OP_HOLD_OFF: next_st.hold = 1'b0;
						`RSEQ_OP_RTD_SRC:
						begin
							if (st.ctx[`RSEQ_CTX_SPRT])
								new_code = `RSEQ_E_SPRT; // [RQ11]
						end
						`RSEQ_OP_SPRT:
						begin
							if (st.ctx[`RSEQ_CTX_RTD_SRC])
								new_code = `RSEQ_E_SPRT; // [RQ11]
						end
						`RSEQ_OP_NUM_LEN:
						begin
							if (i_wb.dat[15:8] > `RSEQ_NUM_MAX)
								new_code = `RSEQ_E_NUM_LEN; // [RQ9]
						end
						`RSEQ_OP_PRES_REQ:
						begin
							if (!st.ctx[`RSEQ_CTX_PRES])
								new_code = `RSEQ_E_ZERO; // [RQ18]
						end
						`RSEQ_OP_NON_NUM: new_code = `RSEQ_E_NON_NUM; // [RQ8]
						`RSEQ_OP_BAD_UNITS: new_code = `RSEQ_E_UNITS; // [RQ10]
						`RSEQ_OP_MISSING: new_code = `RSEQ_E_MISSING; // [RQ13]
						`RSEQ_OP_BAD_TUNIT,
						`RSEQ_OP_BAD_PUNIT: new_code = `RSEQ_E_TUNIT; // [RQ14]
						`RSEQ_OP_BAD_HOLD: new_code = `RSEQ_E_HOLD_PAR; // [RQ15]
						`RSEQ_OP_BAD_KIND: new_code = `RSEQ_E_KIND; // [RQ17]
						`RSEQ_OP_BAD_JREF: new_code = `RSEQ_E_JREF; // [RQ17]
						`RSEQ_OP_BAD_TSEL: new_code = `RSEQ_E_TSEL; // [RQ17]
						`RSEQ_OP_DONE: next_st.esr[`RSEQ_ESR_OPC] = 1'b1; // [RQ21]
						default: new_code = `RSEQ_E_UNKNOWN; // [RQ20]
					endcase
				end
				default: ;
			endcase
		end
		// register reads; the fault read pops the stack
		if (rd)
		begin
			case (i_wb.adr)
				`RSEQ_ADR_STATE:
				begin
					next_st.rdat = {20'h0, st.cnt, 4'h0, st.hold, st.out_on, st.mode};
				end
				`RSEQ_ADR_CTX: next_st.rdat = {24'h0, st.ctx};
				`RSEQ_ADR_LIM_HI: next_st.rdat = {16'h0, st.lim_hi};
				`RSEQ_ADR_LIM_LO: next_st.rdat = {16'h0, st.lim_lo};
				`RSEQ_ADR_ESR: next_st.rdat = {24'h0, st.esr};
				`RSEQ_ADR_FAULT:
				begin
					if (st.cnt != 4'h0)
					begin
						next_st.rdat = {25'h0, st.stk[0]}; // [RQ4]
						next_st.stk = stk_pop; // [RQ4]
						next_st.cnt = st.cnt - 4'h1;
					end
					else
					begin
						next_st.rdat = 32'h0000_0000; // [RQ5]
					end
				end
				default: next_st.rdat = 32'h0000_0000;
			endcase
		end
		// log a new code: push, or mark overflow in the newest slot
		if (new_code != `RSEQ_E_NONE)
		begin
			if (st.cnt == `RSEQ_Q_FULL)
			begin
				next_st.stk[0] = `RSEQ_E_OVF; // [RQ6]
				next_st.esr = next_st.esr | class_bit(code_class(`RSEQ_E_OVF)); // [RQ22]
			end
			else
			begin
				next_st.stk = stk_push;
				next_st.cnt = st.cnt + 4'h1;
				next_st.esr = next_st.esr | class_bit(code_class(new_code)); // [RQ22]
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************

	// all state in one flop bank
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st <= '0;
			st.mode <= RSEQ_LOCAL;
			st.ctx <= `RSEQ_CTX_RST;
			st.lim_hi <= `RSEQ_LIM_HI_RST;
			st.lim_lo <= `RSEQ_LIM_LO_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	assign o_wb_ack = st.ack;
	assign o_wb_dat = st.rdat;
	assign o_remote = (st.mode != RSEQ_LOCAL); // lockout implies remote
	assign o_panel_locked = (st.mode == RSEQ_LOCKOUT);
	assign o_output_active = st.out_on;
	assign o_range_hold = st.hold;
endmodule

// [verif/rseq_chk.sv]
`timescale 1ns/1ps
module rseq_chk
	import rseq_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire rseq_wb_req_t i_wb,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_remote,
	input wire logic o_panel_locked,
	input wire logic o_output_active,
	input wire logic o_range_hold
);
	// ********
	// taken access and full-word command write
	// ********
	wire tk = i_wb.cyc & i_wb.stb & ~o_wb_ack;
	wire cw = tk & i_wb.we & (i_wb.adr == 8'h08) & (i_wb.sel == 4'hf);
	wire [4:0] op = i_wb.dat[4:0];
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_ack_lat;
		tk |=> o_wb_ack ##1 !o_wb_ack;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
	property p_local;
		cw && op == 5'h01 |=> !o_remote && !o_panel_locked;
	endproperty
	a_local: assert property (p_local) else $error("local command failed");
	property p_lock;
		cw && op == 5'h02 |=> o_remote && o_panel_locked;
	endproperty
	a_lock: assert property (p_lock) else $error("lockout command failed");
	property p_remote;
		cw && op == 5'h03 |=> o_remote && (o_panel_locked == $past(o_panel_locked));
	endproperty
	a_remote: assert property (p_remote) else $error("remote command failed");
	property p_lock_rem;
		o_panel_locked |-> o_remote;
	endproperty
	a_lock_rem: assert property (p_lock_rem) else $error("locked but not remote");
	property p_mode_chg;
		$changed(o_remote) |-> $past(cw && op inside {5'h01, 5'h02, 5'h03});
	endproperty
	a_mode_chg: assert property (p_mode_chg) else $error("mode moved alone");
	property p_hold_chg;
		$changed(o_range_hold) |-> $past(cw && op inside {5'h06, 5'h07});
	endproperty
	a_hold_chg: assert property (p_hold_chg) else $error("hold moved alone");
	property p_out_chg;
		$changed(o_output_active) |-> $past(cw && op inside {5'h04, 5'h05});
	endproperty
	a_out_chg: assert property (p_out_chg) else $error("output moved alone");
	// main scenarios reached
	c_lock: cover property (cw && op == 5'h02);
	c_hold: cover property ($rose(o_range_hold));
	c_pop: cover property (tk && !i_wb.we && i_wb.adr == 8'h1c);
endmodule
bind rseq_top rseq_chk i_rseq_chk (.i_clk, .i_rst, .i_wb, .o_wb_ack, .o_wb_dat, .o_remote,
	.o_panel_locked, .o_output_active, .o_range_hold);

// [verif/rseq_host.sv]
`timescale 1ns/1ps
module rseq_host
	import rseq_pkg::*;
(
	input wire logic i_clk,
	output rseq_wb_req_t o_wb,
	input wire logic i_ack,
	input wire logic [31:0] i_dat
);
	// idle bus at time zero
	initial o_wb = '0;
	// one classic cycle; data line scrambled once released so stale data never matches
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		o_wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
		@(posedge i_clk);
		while (i_ack !== 1'b1 && n < 50)
		begin
			@(posedge i_clk);
			n++;
		end
		q = i_dat;
		o_wb.cyc <= 1'b0;
		o_wb.stb <= 1'b0;
		o_wb.dat <= ~d;
		@(posedge i_clk);
	endtask
endmodule

// [verif/rseq_test.sv]
`timescale 1ns/1ps
module rseq_test;
	import rseq_pkg::*;
	logic clk, rst, ack, remote, locked, outa, hold;
	logic [31:0] dat, q;
	rseq_wb_req_t wb;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [4:0] mop[6] = '{2, 1, 3, 2, 3, 1};
	logic [1:0] mex[6] = '{3, 0, 2, 3, 3, 0};
	int qex[8] = '{1, 113, 112, 110, 109, 108, 103, 101};
	logic [4:0] qop[9] = '{5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
	logic [15:0] ent[4] = '{16'h0101, 16'h0100, 16'hfeff, 16'hff00};
	rseq_top i_rseq_top (.i_clk(clk), .i_rst(rst), .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(dat),
		.o_remote(remote), .o_panel_locked(locked), .o_output_active(outa), .o_range_hold(hold));
	rseq_host i_rseq_host (.i_clk(clk), .o_wb(wb), .i_ack(ack), .i_dat(dat));
	// ********
	// clock, hang guard, helpers
	// ********
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// whole run needs well under this many cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			err_count++;
			print_verdict();
		end
	end
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_rseq_host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a);
		i_rseq_host.xfer(1'b0, a, 32'h0, q);
	endtask
	// logged code must pop once, leave queue empty, and flag its class
	task log_chk(input logic [7:0] a, input logic [31:0] d, input int e, input int s);
		wr(8'h20, 32'hff);
		wr(a, d);
		rd(8'h1c);
		chk(q, e);
		rd(8'h1c);
		chk(q, 0);
		rd(8'h20);
		chk(q, s);
	endtask
	function automatic int cls(int e);
		if (e == 0)
			return 0;
		return e inside {101, 103, 108, 109, 110, 112, 113, 114, 117} ? 32'h20 : 32'h10;
	endfunction
	function automatic int exp_code(logic [7:0] c, logic [4:0] op, logic [7:0] a);
		case (op)
			5'h01, 5'h02, 5'h03, 5'h07, 5'h16: return 0;
			5'h04, 5'h05: return (c[0] | c[1]) ? 100 : 0;
			5'h06: return c[4] ? 0 : 111;
			5'h08: return c[3] ? 104 : 0;
			5'h09: return c[2] ? 104 : 0;
			5'h0a: return a > 10 ? 102 : 0;
			5'h0b: return c[5] ? 0 : 116;
			5'h0c: return 101;
			5'h0d: return 103;
			5'h0e: return 108;
			5'h0f, 5'h10: return 109;
			5'h11: return 110;
			5'h12: return 112;
			5'h13: return 113;
			5'h14: return 114;
			default: return 117;
		endcase
	endfunction
	function automatic int zlim(logic [7:0] c, int k);
		return k == 0 ? 600 : k == 1 ? 1000 : c[6] ? 100 : 10;
	endfunction
	// ********
	// main sequence
	// ********
	initial
	begin
		logic [7:0] c, a;
		logic [4:0] op;
		logic [15:0] v;
		int k, e, m;
		logic eo, eh;
		eo = 1'b0;
		eh = 1'b0;
		rst = 1;
		void'($urandom(32'hf937));
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(8'h00);
		chk(q, 0);
		rd(8'h1c);
		chk(q, 0);
		rd(8'h40);
		chk(q, 0);
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h08, {27'h0, mop[i]});
			chk({remote, locked}, mex[i]);
		end
		$display("test modes done");
		for (int i = 0; i < 200; i++)
		begin
			c = $urandom;
			op = $urandom;
			a = $urandom % 16;
			if (i < 2)
			begin
				op = 5'h0a;
				a = 10 + i;
			end
			wr(8'h04, {24'h0, c});
			e = exp_code(c, op, a);
			log_chk(8'h08, {16'h0, a, 3'h0, op}, e, (op == 5'h16) ? 1 : cls(e));
			// output and hold only move on accepted commands
			if (e == 0 && (op == 5'h04 || op == 5'h05))
				eo = (op == 5'h04);
			if (e == 0 && op == 5'h06)
				eh = 1'b1;
			if (op == 5'h07)
				eh = 1'b0;
			chk({30'h0, outa, hold}, {30'h0, eo, eh});
		end
		$display("test commands done");
		wr(8'h10, 32'h0100);
		wr(8'h14, 32'hff00);
		for (int i = 0; i < 20; i++)
		begin
			v = (i < 4) ? ent[i] : 16'($urandom);
			e = $signed(v) > 16'sh0100 ? 105 : $signed(v) < -16'sh0100 ? 106 : 0;
			log_chk(8'h0c, {16'h0, v}, e, cls(e));
		end
		$display("test limits done");
		for (int i = 0; i < 60; i++)
		begin
			c = $urandom;
			k = $urandom % 3;
			v = 16'(zlim(c, k) + ($urandom % 3) - 1);
			if ($urandom % 2)
				v = -v;
			// magnitude taken as a signed int so the negation is not widened unsigned
			m = $signed(v);
			if (m < 0)
				m = -m;
			e = ((k == 0 && !c[5]) || zlim(c, k) < m) ? 116 : 0;
			wr(8'h04, {24'h0, c});
			log_chk(8'h18, {14'h0, 2'(k), v}, e, cls(e));
		end
		$display("test zero done");
		wr(8'h20, 32'hff);
		for (int i = 0; i < 9; i++)
			wr(8'h08, {27'h0, qop[i]});
		rd(8'h00);
		chk(q[11:8], 4'h8);
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h1c);
			chk(q, qex[i]);
		end
		rd(8'h1c);
		chk(q, 0);
		rd(8'h20);
		chk(q, 32'h28);
		$display("test overflow done");
		print_verdict();
	end
endmodule
